// [logic/mic_pkg.sv]
// Constants, field positions and carrier types for the interrupt controller
package mic_pkg;
    localparam int PC_W = 11;
    localparam int AW = 8;
    localparam int NSRC = 5;
    localparam int NTM = 4;
    localparam int NPIN = 2;
    localparam int EDGE_W = 2;
    localparam int SRC_W = 3;
    // Register byte offsets
    localparam logic [AW-1:0] OFS_EDGE = 8'h00;
    localparam logic [AW-1:0] OFS_CTRL0 = 8'h04;
    localparam logic [AW-1:0] OFS_CTRL1 = 8'h08;
    localparam logic [AW-1:0] OFS_GRP0 = 8'h0C;
    localparam logic [AW-1:0] OFS_GRP1 = 8'h10;
    // Source index doubles as priority, lowest index wins
    localparam int SRC_PIN_A = 0;
    localparam int SRC_GRP0 = 1;
    localparam int SRC_NVM = 2;
    localparam int SRC_ADC = 3;
    localparam int SRC_SLOT7 = 4;
    // First control register fields
    localparam int B0_GIE = 0;
    localparam int B0_PIN_A_EN = 1;
    localparam int B0_PIN_A_FLAG = 4;
    // Second control register: enable at position, flag at position plus FLAG_OFS
    localparam int B1_GRP0 = 0;
    localparam int B1_NVM = 1;
    localparam int B1_ADC = 2;
    localparam int B1_SLOT7 = 3;
    localparam int FLAG_OFS = 4;
    // Edge select codes
    localparam logic [EDGE_W-1:0] EDGE_OFF = 2'h0;
    localparam logic [EDGE_W-1:0] EDGE_RISE = 2'h1;
    localparam logic [EDGE_W-1:0] EDGE_FALL = 2'h2;
    localparam logic [EDGE_W-1:0] EDGE_BOTH = 2'h3;
    // Vector addresses
    localparam logic [PC_W-1:0] VEC_PIN_A = 11'h004;
    localparam logic [PC_W-1:0] VEC_GRP0 = 11'h008;
    localparam logic [PC_W-1:0] VEC_NVM = 11'h00C;
    localparam logic [PC_W-1:0] VEC_ADC = 11'h010;
    localparam logic [PC_W-1:0] VEC_SLOT7 = 11'h014;
    // Timer member masks: [0] t0 P, [1] t0 A, [2] t1 P, [3] t1 A
    localparam logic [NTM-1:0] TM_GRP0_DUAL = 4'hF;
    localparam logic [NTM-1:0] TM_GRP0_SINGLE = 4'h3;
    localparam logic [NTM-1:0] TM_GRP1 = 4'hC;
    localparam logic [1:0] ZERO2 = 2'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [23:0] RD_PAD = 24'h00_0000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [AW-1:0] paddr;
        logic [31:0] pwdata;
    } mic_apb_s;

    typedef struct packed {
        logic instr_boundary;
        logic return_from_irq_instr_exec;
        logic stack_full;
        logic sleeping;
        logic [PC_W-1:0] pc_next;
        logic [PC_W-1:0] stack_top;
    } mic_cpu_s;

    typedef struct packed {
        logic stack_push;
        logic [PC_W-1:0] push_addr;
        logic stack_pop;
        logic pc_load;
        logic [PC_W-1:0] pc_load_addr;
        logic irq_taken;
        logic [SRC_W-1:0] irq_src;
    } mic_cpu_out_s;

    typedef struct packed {
        logic [NPIN-1:0] sync1;
        logic [NPIN-1:0] sync2;
        logic [NPIN-1:0] prev;
        logic [NPIN*EDGE_W-1:0] edge_sel;
        logic gie;
        logic [NSRC-1:0] flag;
        logic [NSRC-1:0] en;
        logic [NTM-1:0] tm_flag;
        logic [NTM-1:0] tm_en;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic wake_req;
        mic_cpu_out_s out;
    } mic_state_s;
endpackage

// [logic/mic_irq_ctrl.sv]
// Interrupt flag, enable, arbitration and vectoring logic with APB registers
`timescale 1ns/1ps
module mic_irq_ctrl
    import mic_pkg::*;
#(
    parameter bit SECOND_PIN = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire mic_apb_s apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPIN-1:0] ext_pin,
    input wire logic adc_done,
    input wire logic nvm_done,
    input wire logic [NTM-1:0] tm_evt,
    input wire mic_cpu_s cpu,
    output mic_cpu_out_s cpu_out,
    output logic wake_req
);

    mic_state_s s_r;
    mic_state_s s_nxt;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] hw_set;
    logic [NPIN-1:0] pin_hit;
    logic [SRC_W-1:0] win;
    logic take;
    logic wr_fire;
    logic [7:0] wb;
    logic [NTM-1:0] grp0_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Lowest pending index wins
    function automatic logic [SRC_W-1:0] first_set(input logic [NSRC-1:0] v);
        logic [SRC_W-1:0] r;
        r = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
                r = SRC_W'(i);
        end
        return r;
    endfunction

    function automatic logic [PC_W-1:0] vec_of(input logic [SRC_W-1:0] i);
        logic [PC_W-1:0] v;
        v = VEC_SLOT7;
        if (i == SRC_W'(SRC_PIN_A))
            v = VEC_PIN_A;
        else if (i == SRC_W'(SRC_GRP0))
            v = VEC_GRP0;
        else if (i == SRC_W'(SRC_NVM))
            v = VEC_NVM;
        else if (i == SRC_W'(SRC_ADC))
            v = VEC_ADC;
        return v;
    endfunction

    // Two-member group layout: A flag above P flag, enables in low half
    function automatic logic [7:0] grp_pack(input logic [1:0] f, input logic [1:0] e);
        return {ZERO2, f, ZERO2, e};
    endfunction

    function automatic logic edge_match(input logic [EDGE_W-1:0] sel, input logic now,
                                        input logic was);
        logic r;
        r = 1'b0;
        case (sel)
            EDGE_RISE: r = now & ~was;
            EDGE_FALL: r = ~now & was;
            EDGE_BOTH: r = now ^ was;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic is_mapped(input logic [AW-1:0] a);
        logic m;
        m = 1'b0;
        if (a == OFS_EDGE || a == OFS_CTRL0 || a == OFS_CTRL1 || a == OFS_GRP0)
            m = 1'b1;
        else if (a == OFS_GRP1)
            m = !SECOND_PIN;
        return m;
    endfunction

    // Unimplemented bits read as zero
    function automatic logic [31:0] rd_reg(input logic [AW-1:0] a, input mic_state_s s);
        logic [7:0] b;
        b = RST_BYTE;
        if (a == OFS_EDGE)
        begin
            b[EDGE_W-1:0] = s.edge_sel[EDGE_W-1:0];
            if (SECOND_PIN)
                b[NPIN*EDGE_W-1:EDGE_W] = s.edge_sel[NPIN*EDGE_W-1:EDGE_W];
        end
        else if (a == OFS_CTRL0)
        begin
            b[B0_GIE] = s.gie;
            b[B0_PIN_A_EN] = s.en[SRC_PIN_A];
            b[B0_PIN_A_FLAG] = s.flag[SRC_PIN_A];
        end
        else if (a == OFS_CTRL1)
        begin
            b[B1_GRP0] = s.en[SRC_GRP0];
            b[B1_NVM] = s.en[SRC_NVM];
            b[B1_ADC] = s.en[SRC_ADC];
            b[B1_SLOT7] = s.en[SRC_SLOT7];
            b[FLAG_OFS + B1_GRP0] = s.flag[SRC_GRP0];
            b[FLAG_OFS + B1_NVM] = s.flag[SRC_NVM];
            b[FLAG_OFS + B1_ADC] = s.flag[SRC_ADC];
            b[FLAG_OFS + B1_SLOT7] = s.flag[SRC_SLOT7];
        end
        else if (a == OFS_GRP0)
        begin
            if (SECOND_PIN)
                b = {s.tm_flag, s.tm_en};
            else
                b = grp_pack(s.tm_flag[1:0], s.tm_en[1:0]);
        end
        else if (a == OFS_GRP1 && !SECOND_PIN)
            b = grp_pack(s.tm_flag[3:2], s.tm_en[3:2]);
        return {RD_PAD, b};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Event detection and arbitration

    // Edge detect reads the second sync stage only
    always_comb
    begin
        for (int p = 0; p < NPIN; p++)
            pin_hit[p] = edge_match(s_r.edge_sel[p*EDGE_W +: EDGE_W], s_r.sync2[p],
                                    s_r.prev[p]);
    end

    assign grp0_mask = SECOND_PIN ? TM_GRP0_DUAL : TM_GRP0_SINGLE;

    // Hardware set sources; group flags follow enabled members
    always_comb
    begin
        hw_set = '0;
        hw_set[SRC_PIN_A] = pin_hit[SRC_PIN_A];
        hw_set[SRC_GRP0] = |(tm_evt & s_r.tm_en & grp0_mask);
        hw_set[SRC_NVM] = nvm_done;
        hw_set[SRC_ADC] = adc_done;
        hw_set[SRC_SLOT7] = SECOND_PIN ? pin_hit[1] : |(tm_evt & s_r.tm_en & TM_GRP1);
    end

    // Only enabled flags compete, at a boundary, with room on the stack
    assign pend = s_r.flag & s_r.en;
    assign win = first_set(pend);
    assign take = cpu.instr_boundary && !cpu.return_from_irq_instr_exec && s_r.gie && !cpu.stack_full
                  && (|pend);
    assign wr_fire = apb.psel && apb.penable && s_r.pready && apb.pwrite;
    assign wb = apb.pwdata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Order matters: software write, then service clear, then hardware set,
    // so an event landing on the clearing cycle is never lost
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.sync1 = ext_pin;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev = s_r.sync2;
        s_nxt.out.stack_push = 1'b0;
        s_nxt.out.stack_pop = 1'b0;
        s_nxt.out.pc_load = 1'b0;
        s_nxt.out.irq_taken = 1'b0;
        // APB: setup cycle loads read data, access cycle completes
        s_nxt.pready = apb.psel && !apb.penable;
        s_nxt.pslverr = apb.psel && !apb.penable && !is_mapped(apb.paddr);
        s_nxt.prdata = (apb.psel && !apb.penable && !apb.pwrite) ? rd_reg(apb.paddr, s_r) : '0;
        // Register writes, implemented bits read-write, others dropped
        if (wr_fire)
        begin
            if (apb.paddr == OFS_EDGE)
            begin
                s_nxt.edge_sel[EDGE_W-1:0] = wb[EDGE_W-1:0];
                if (SECOND_PIN)
                    s_nxt.edge_sel[NPIN*EDGE_W-1:EDGE_W] = wb[NPIN*EDGE_W-1:EDGE_W];
            end
            else if (apb.paddr == OFS_CTRL0)
            begin
                s_nxt.gie = wb[B0_GIE];
                s_nxt.en[SRC_PIN_A] = wb[B0_PIN_A_EN];
                s_nxt.flag[SRC_PIN_A] = wb[B0_PIN_A_FLAG];
            end
            else if (apb.paddr == OFS_CTRL1)
            begin
                s_nxt.en[SRC_GRP0] = wb[B1_GRP0];
                s_nxt.en[SRC_NVM] = wb[B1_NVM];
                s_nxt.en[SRC_ADC] = wb[B1_ADC];
                s_nxt.en[SRC_SLOT7] = wb[B1_SLOT7];
                s_nxt.flag[SRC_GRP0] = wb[FLAG_OFS + B1_GRP0];
                s_nxt.flag[SRC_NVM] = wb[FLAG_OFS + B1_NVM];
                s_nxt.flag[SRC_ADC] = wb[FLAG_OFS + B1_ADC];
                s_nxt.flag[SRC_SLOT7] = wb[FLAG_OFS + B1_SLOT7];
            end
            else if (apb.paddr == OFS_GRP0)
            begin
                if (SECOND_PIN)
                    {s_nxt.tm_flag, s_nxt.tm_en} = wb;
                else
                begin
                    s_nxt.tm_flag[1:0] = wb[FLAG_OFS+1:FLAG_OFS];
                    s_nxt.tm_en[1:0] = wb[1:0];
                end
            end
            else if (apb.paddr == OFS_GRP1 && !SECOND_PIN)
            begin
                s_nxt.tm_flag[3:2] = wb[FLAG_OFS+1:FLAG_OFS];
                s_nxt.tm_en[3:2] = wb[1:0];
            end
        end
        // Return pops the saved address
        if (cpu.instr_boundary && cpu.return_from_irq_instr_exec)
        begin
            s_nxt.out.stack_pop = 1'b1;
            s_nxt.out.pc_load = 1'b1;
            s_nxt.out.pc_load_addr = cpu.stack_top;
        end
        // Accept: push, vector, clear own flag only and global enable
        else if (take)
        begin
            s_nxt.out.stack_push = 1'b1;
            s_nxt.out.push_addr = cpu.pc_next;
            s_nxt.out.pc_load = 1'b1;
            s_nxt.out.pc_load_addr = vec_of(win);
            s_nxt.out.irq_taken = 1'b1;
            s_nxt.out.irq_src = win;
            s_nxt.gie = 1'b0;
            s_nxt.flag[win] = 1'b0;
        end
        // Flags latch even while blocked; set wins over any clear
        s_nxt.flag = s_nxt.flag | hw_set;
        s_nxt.tm_flag = s_nxt.tm_flag | tm_evt;
        // Wake on any rise, enables ignored
        s_nxt.wake_req = cpu.sleeping && ((|(s_nxt.flag & ~s_r.flag))
                         || (|(s_nxt.tm_flag & ~s_r.tm_flag)));
    end

    // State register; clock enable freezes everything
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '0;
        else if (ce)
            s_r <= s_nxt;
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign cpu_out = s_r.out;
    assign wake_req = s_r.wake_req;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Helper copy of competing requests, seen one cycle after the decision
    logic [NSRC-1:0] pend_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_q <= '0;
        else if (ce)
            pend_q <= pend;
    end

    sequence seq_apb_setup;
        apb.psel && !apb.penable && ce;
    endsequence

    sequence seq_apb_access;
        apb.psel && apb.penable && pready;
    endsequence

    a_apb_one_wait: assert property (seq_apb_setup |=> pready)
        else $error("APB access not answered in one cycle");
    a_apb_single_pulse: assert property (seq_apb_access ##0 ce |=> !pready)
        else $error("pready stayed high after access");
    a_gie_blocks: assert property (ce && !s_r.gie |=> !cpu_out.irq_taken)
        else $error("Interrupt taken with global enable low");
    a_full_blocks: assert property (ce && cpu.stack_full |=> !cpu_out.irq_taken)
        else $error("Interrupt taken with stack full");
    a_prio_enable: assert property (cpu_out.irq_taken |-> pend_q[cpu_out.irq_src]
        && ((pend_q & ((NSRC'(1) << cpu_out.irq_src) - NSRC'(1))) == '0))
        else $error("Wrong or disabled source taken");
    a_take_push: assert property (cpu_out.irq_taken |-> cpu_out.stack_push
        && cpu_out.pc_load && cpu_out.push_addr == $past(cpu.pc_next)
        && cpu_out.pc_load_addr == vec_of(cpu_out.irq_src))
        else $error("Accept did not push and vector");
    a_take_clears: assert property (cpu_out.irq_taken |-> !s_r.gie)
        else $error("Global enable not cleared on accept");
    a_return_from_irq_instr_pop: assert property (ce && cpu.instr_boundary && cpu.return_from_irq_instr_exec
        |=> cpu_out.stack_pop && cpu_out.pc_load && cpu_out.pc_load_addr == $past(cpu.stack_top))
        else $error("Return did not pop the saved address");
    a_adc_latch: assert property (ce && adc_done |=> s_r.flag[SRC_ADC])
        else $error("A/D done flag lost");
    a_wake_rise: assert property (ce && cpu.sleeping && nvm_done && !s_r.flag[SRC_NVM]
        |=> wake_req)
        else $error("No wake on flag rise");
    a_edge_rise: assert property (ce && s_r.edge_sel[EDGE_W-1:0] == EDGE_RISE
        && s_r.sync2[0] && !s_r.prev[0] |=> s_r.flag[SRC_PIN_A])
        else $error("Rising edge missed on pin A");
    a_edge_off: assert property (ce && s_r.edge_sel[EDGE_W-1:0] == EDGE_OFF
        && !s_r.flag[SRC_PIN_A] && !wr_fire |=> !s_r.flag[SRC_PIN_A])
        else $error("Pin A flag set while disabled");
    a_group_keeps: assert property (cpu_out.irq_taken && !$past(wr_fire)
        |-> (s_r.tm_flag & $past(s_r.tm_flag)) == $past(s_r.tm_flag))
        else $error("Service cleared a member flag");

    // Return owns its boundary, so an accept riding along would lose a stack slot
    a_return_from_irq_instr_wins: assert property (ce && cpu.instr_boundary && cpu.return_from_irq_instr_exec
        |=> !cpu_out.irq_taken)
        else $error("Accept taken on a return boundary");
    a_wake_asleep: assert property (ce && !cpu.sleeping |=> !wake_req)
        else $error("Wake request while awake");
    a_group_set: assert property (ce && (|(tm_evt & s_r.tm_en & grp0_mask))
        |=> s_r.flag[SRC_GRP0])
        else $error("Group flag missed an enabled member event");
    a_apb_decode_err: assert property (seq_apb_setup ##0 !is_mapped(apb.paddr)
        |=> pslverr)
        else $error("Unmapped access answered without error");
    a_no_enabled: assert property (ce && pend == '0 |=> !cpu_out.irq_taken)
        else $error("Interrupt taken with no enabled request");

endmodule

// [test/mic_cpu_model.sv]
// Behavioural CPU sequencer and call stack that faces the interrupt controller
`timescale 1ns/1ps
module mic_cpu_model
    import mic_pkg::*;
#(
    parameter int DEPTH = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic slow,
    input wire logic sleep,
    input wire logic return_from_irq_instr_req,
    input wire mic_cpu_out_s cpu_out,
    output mic_cpu_s cpu
);
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] stk_r [DEPTH];
    logic [3:0] sp_r;
    logic [1:0] cnt_r;
    logic bnd_r;
    logic return_from_irq_instr_r;
    logic pend_r;
    logic bnd;
    ////////////////////////////////////////////////////////////////////////////
    // Slow mode spaces boundaries four cycles apart, like multi-cycle instructions
    assign bnd = run && (!slow || cnt_r == 2'h0);
    // Sequencer state; a return request waits for the next boundary
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_r <= 11'h100;
            sp_r <= 4'h0;
            cnt_r <= 2'h0;
            bnd_r <= 1'b0;
            return_from_irq_instr_r <= 1'b0;
            pend_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_r + 2'h1;
            bnd_r <= bnd;
            return_from_irq_instr_r <= bnd && (pend_r || return_from_irq_instr_req);
            pend_r <= (pend_r || return_from_irq_instr_req) && !bnd;
            if (cpu_out.pc_load)
                pc_r <= cpu_out.pc_load_addr;
            else if (bnd)
                pc_r <= pc_r + 11'h001;
            if (cpu_out.stack_push)
            begin
                stk_r[sp_r] <= cpu_out.push_addr;
                sp_r <= sp_r + 4'h1;
            end
            else if (cpu_out.stack_pop)
                sp_r <= sp_r - 4'h1;
        end
    end
    // An empty stack shows a changing value, never a stale saved address
    always_comb
    begin
        cpu.instr_boundary = bnd_r;
        cpu.return_from_irq_instr_exec = return_from_irq_instr_r;
        cpu.stack_full = (sp_r == 4'(DEPTH));
        cpu.sleeping = sleep;
        cpu.pc_next = pc_r + 11'h001;
        cpu.stack_top = (sp_r == 4'h0) ? ~pc_r : stk_r[sp_r - 4'h1];
    end
endmodule

// [test/tb.sv]
// Self-checking bench for the interrupt controller with a CPU sequencer model
`timescale 1ns/1ps
module tb
    import mic_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, ce, adc_done, nvm_done, run, slow, sleep, return_from_irq_instr_req;
    logic [NPIN-1:0] ext_pin;
    logic [NTM-1:0] tm_evt, ev;
    mic_apb_s apb;
    logic [31:0] prdata, lfsr;
    logic pready, pslverr, wake_req, g;
    mic_cpu_s cpu;
    mic_cpu_out_s cpu_out;
    logic [32:0] exp_rd [$];
    logic [13:0] exp_irq [$];
    logic [PC_W-1:0] ret_stk [$];
    logic [PC_W-1:0] last_pc;
    logic [1:0] cd, cb;
    int mismatches, check_count, cycles, wakes, w;
    ////////////////////////////////////////////////////////////////////////////
    // Clock, design and partner
    always #2 pclk = ~pclk;
    mic_irq_ctrl #(.SECOND_PIN(1'b1)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_pin(ext_pin),
        .adc_done(adc_done), .nvm_done(nvm_done), .tm_evt(tm_evt), .cpu(cpu),
        .cpu_out(cpu_out), .wake_req(wake_req));
    mic_cpu_model #(.DEPTH(2)) i_cpu (.pclk(pclk), .presetn(presetn), .run(run), .slow(slow),
        .sleep(sleep), .return_from_irq_instr_req(return_from_irq_instr_req), .cpu_out(cpu_out), .cpu(cpu));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
        check_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // One APB transfer; the request holds until pready is seen high at an edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] b,
        input logic e);
        int n;
        exp_rd.push_back(wr ? {e, 32'h0000_0000} : {e, 24'h00_0000, b});
        @(posedge pclk);
        apb <= '{1'b1, 1'b0, wr, a, {lfsr[31:8], b}};
        lfsr = lfsr_next(lfsr);
        @(posedge pclk);
        apb.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        if (n >= 20)
            chk("pready", 33'h0_0000_0001, 33'h0_0000_0000);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] b, input logic e = 1'b0);
        xfer(1'b1, a, b, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] b, input logic e = 1'b0);
        xfer(1'b0, a, b, e);
    endtask
    task automatic pulse(input logic a, input logic n, input logic [3:0] t);
        @(posedge pclk);
        adc_done <= a;
        nvm_done <= n;
        tm_evt <= t;
        @(posedge pclk);
        adc_done <= 1'b0;
        nvm_done <= 1'b0;
        tm_evt <= 4'h0;
    endtask
    task automatic ret;
        @(posedge pclk);
        return_from_irq_instr_req <= 1'b1;
        @(posedge pclk);
        return_from_irq_instr_req <= 1'b0;
        repeat (10) @(posedge pclk);
    endtask
    // Waits until the watcher has seen every announced interrupt
    task automatic wait_irq;
        int n;
        n = 0;
        while (exp_irq.size() != 0 && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        chk("pending irq", 33'h0, 33'(exp_irq.size()));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watcher at the falling edge, where every registered output has settled
    always @(negedge pclk)
    begin
        if (apb.psel && apb.penable && pready === 1'b1)
            chk("apb", exp_rd.size() ? exp_rd.pop_front() : 33'h1_FFFF_FFFF,
                {pslverr, prdata});
        if (cpu_out.irq_taken === 1'b1)
        begin
            chk("vector", exp_irq.size() ? exp_irq.pop_front() : 14'h3FFF,
                {cpu_out.irq_src, cpu_out.pc_load_addr});
            chk("push", last_pc, cpu_out.push_addr);
            ret_stk.push_back(last_pc);
        end
        if (cpu_out.stack_pop === 1'b1)
            chk("return", ret_stk.pop_back(), cpu_out.pc_load_addr);
        if (cpu.instr_boundary)
            last_pc = cpu.pc_next;
        if (wake_req === 1'b1)
            wakes++;
    end
    // Hang guard
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {presetn, adc_done, nvm_done, run, slow, sleep, return_from_irq_instr_req} = 7'h00;
        ce = 1'b1;
        ext_pin = 2'h0;
        tm_evt = 4'h0;
        apb = '0;
        lfsr = 32'h5416_2cb1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, masks of unused bits and unmapped places
        for (int i = 0; i < 4; i++)
            rd(8'(4 * i), 8'h00);
        rd(OFS_GRP1, 8'h00, 1'b1);
        wr(8'h14, 8'hFF, 1'b1);
        rd(8'h14, 8'h00, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'(4 * i), 8'hFF);
            rd(8'(4 * i), i == 0 ? 8'h0F : i == 1 ? 8'h13 : 8'hFF);
            wr(8'(4 * i), 8'h00);
        end
        // Events while blocked, then priority on release
        run <= 1'b1;
        wr(OFS_CTRL1, 8'h06);
        pulse(1'b1, 1'b1, 4'h0);
        rd(OFS_CTRL1, 8'h66);
        exp_irq.push_back({3'(SRC_NVM), VEC_NVM});
        wr(OFS_CTRL0, 8'h01);
        wait_irq();
        rd(OFS_CTRL0, 8'h00);
        rd(OFS_CTRL1, 8'h46);
        // Nesting until the stack is full, then a held request after a return
        slow <= 1'b1;
        exp_irq.push_back({3'(SRC_ADC), VEC_ADC});
        wr(OFS_CTRL0, 8'h01);
        wait_irq();
        pulse(1'b1, 1'b0, 4'h0);
        wr(OFS_CTRL0, 8'h01);
        repeat (20) @(posedge pclk);
        rd(OFS_CTRL1, 8'h46);
        exp_irq.push_back({3'(SRC_ADC), VEC_ADC});
        ret();
        wait_irq();
        ret();
        ret();
        slow <= 1'b0;
        // Every edge code on both pins, rising then falling
        wr(OFS_CTRL1, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            cd = 2'(c);
            cb = ~cd;
            wr(OFS_EDGE, {4'h0, cb, cd});
            wr(OFS_CTRL0, 8'h00);
            wr(OFS_CTRL1, 8'h00);
            ext_pin <= 2'h3;
            repeat (6) @(posedge pclk);
            rd(OFS_CTRL0, {3'h0, cd[0], 4'h0});
            rd(OFS_CTRL1, {cb[0], 7'h00});
            wr(OFS_CTRL0, 8'h00);
            wr(OFS_CTRL1, 8'h00);
            ext_pin <= 2'h0;
            repeat (6) @(posedge pclk);
            rd(OFS_CTRL0, {3'h0, cd[1], 4'h0});
            rd(OFS_CTRL1, {cb[1], 7'h00});
        end
        exp_irq.push_back({3'(SRC_PIN_A), VEC_PIN_A});
        wr(OFS_CTRL0, 8'h13);
        wait_irq();
        rd(OFS_CTRL0, 8'h02);
        ret();
        // Group flag follows enabled members; service leaves members set
        wr(OFS_CTRL1, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            wr(OFS_GRP0, 8'h07);
            ev = (i == 0) ? 4'h8 : lfsr[3:0];
            lfsr = lfsr_next(lfsr);
            g = |(ev & 4'h7);
            pulse(1'b0, 1'b0, ev);
            rd(OFS_GRP0, {ev, 4'h7});
            rd(OFS_CTRL1, {3'h0, g, 4'h1});
            if (g)
            begin
                exp_irq.push_back({3'(SRC_GRP0), VEC_GRP0});
                wr(OFS_CTRL0, 8'h01);
                wait_irq();
                rd(OFS_GRP0, {ev, 4'h7});
                rd(OFS_CTRL1, 8'h01);
                ret();
            end
        end
        // Wake-up on a rising flag only, with every source enable clear
        wr(OFS_CTRL1, 8'h00);
        wr(OFS_CTRL0, 8'h01);
        sleep <= 1'b1;
        w = wakes;
        pulse(1'b1, 1'b0, 4'h0);
        repeat (4) @(posedge pclk);
        chk("wake", 33'(w + 1), 33'(wakes));
        pulse(1'b1, 1'b0, 4'h0);
        repeat (4) @(posedge pclk);
        chk("wake", 33'(w + 1), 33'(wakes));
        rd(OFS_CTRL0, 8'h01);
        sleep <= 1'b0;
        end_of_test();
    end
endmodule
